// ### common/pdr_pkg.sv
// Constants for the synthesizer dither and pump/reference configuration bank.
// Assumes a serial host shifting 24-bit words and an APB master reading back.
// What this block does
// - 24-bit word, low three bits select target
// - Select 011 loads the dither register
// - 17-bit restart word at bit 3, default one
// - Dither enable bit 20, resets on
// - Magnitude codes give 15, 7, 3, 1
// - Select 100 loads the pump/reference register
// - Bit 18 picks internal or external resistor
// - Current multiplier is one plus bits 11:10
// - Bits 16:12 set the phase offset multiplier
// - Bit 17 sets phase offset sign
// - Reference scaled by two, one, half, quarter
// - Monitor pin selectable, resets to lock detect
// - Pump current is base times multiplier
package pdr_pkg;
  // ----------------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_BITS = 24;
  localparam logic [4:0] LAST_BIT_IDX = 5'h17;  // Count value of the 24th bit
  localparam logic [2:0] SEL_DITHER = 3'h3;
  localparam logic [2:0] SEL_PUMP = 3'h4;
  // Dither register fields
  localparam int unsigned DIT_RESTART_LSB = 3;
  localparam int unsigned DIT_RESTART_MSB = 19;
  localparam int unsigned DIT_ON_POS = 20;
  localparam int unsigned DIT_MAG_LSB = 21;
  localparam int unsigned DIT_MAG_MSB = 22;
  // Pump / reference register fields
  localparam int unsigned CP_MULT_LSB = 10;
  localparam int unsigned CP_MULT_MSB = 11;
  localparam int unsigned OFS_LSB = 12;
  localparam int unsigned OFS_MSB = 16;
  localparam int unsigned OFS_SIGN_POS = 17;
  localparam int unsigned RSET_EXT_POS = 18;
  localparam int unsigned REF_SCALE_LSB = 19;
  localparam int unsigned REF_SCALE_MSB = 20;
  localparam int unsigned MON_SEL_LSB = 21;
  localparam int unsigned MON_SEL_MSB = 23;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] MON_SEL_LOCK = 3'h1;  // Monitor source index of lock detect
  localparam logic [23:0] DITHER_RST = 24'h100008;  // Enable on, magnitude 15, restart 1
  localparam logic [23:0] PUMP_RST = 24'h200004;  // Monitor shows lock detect
  // ----------------------------------------------------------------------
  // APB map (byte addresses); printed register offsets are word indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_DITHER = 8'h03;
  localparam logic [7:0] IDX_PUMP = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DITHER = 8'h0c;  // Four times the dither index
  localparam logic [7:0] ADDR_PUMP = 8'h10;  // Four times the pump index
  localparam logic CTRL_ACCEPT_RST = 1'b1;
endpackage : pdr_pkg

// ### hw/pdr_regs.sv
// Serial-loaded dither and charge pump / reference configuration registers.
// Assumes a host shifting words MSB first on link_clk while link_le is low,
// and an APB master on pclk for readback and the accept control.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module pdr_regs (
  // APB clock, enable and reset
  input wire logic pclk,
  input wire logic pclk_en,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial programming link
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_le,
  // Internal sources offered to the monitor pin (index 1 is lock detect)
  input wire logic [7:0] mon_src,
  // Modulator dither controls
  output logic dither_on_bit,
  output logic [1:0] dither_mag_code,
  output logic [3:0] dither_magnitude,
  output logic [16:0] restart_word,
  // Charge pump, phase detector and reference controls
  output logic pump_rset_external,
  output logic [1:0] pump_mult_code,
  output logic [2:0] pump_current_multiplier,
  output logic [4:0] phase_offset_multiplier,
  output logic phase_offset_negative,
  output logic [1:0] ref_scale_sel,
  output logic [2:0] mon_sel,
  output logic monitor_output_pin
);
  import pdr_pkg::*;

  // ----------------------------------------------------------------------
  // Link domain: shift register and bit counter
  // ----------------------------------------------------------------------
  logic [23:0] shift;  // Bits received so far
  logic [4:0] bit_cnt;  // Index of the next bit
  logic [23:0] hold;  // Last complete word
  logic word_tog;  // Toggles once per complete word
  logic [23:0] next_shift;
  logic [4:0] next_bit_cnt;
  logic [23:0] next_hold;
  logic next_word_tog;

  // The link clock may stop between words, so the word is closed by its
  // own 24th edge rather than by a later edge that might never come.
  always_comb begin
    next_shift = {shift[22:0], link_data};
    next_bit_cnt = bit_cnt + 5'h01;
    next_hold = hold;
    next_word_tog = word_tog;
    if (link_le) begin
      // Latch enable high aborts a partial word
      next_bit_cnt = 5'h00;
      next_shift = shift;
    end else if (bit_cnt == LAST_BIT_IDX) begin
      next_hold = {shift[22:0], link_data};
      next_word_tog = ~word_tog;
      next_bit_cnt = 5'h00;
    end
  end

  // Link-side registers
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      shift <= 24'h000000;
      bit_cnt <= 5'h00;
      hold <= 24'h000000;
      word_tog <= 1'b0;
    end else begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      hold <= next_hold;
      word_tog <= next_word_tog;
    end
  end

  // ----------------------------------------------------------------------
  // Crossing into pclk: toggle synchroniser qualifies the held word
  // ----------------------------------------------------------------------
  logic tog_s1;  // First stage, read only by tog_s2
  logic tog_s2;
  logic tog_s3;
  logic [7:0] mon_s1;  // First stage, read only by mon_s2
  logic [7:0] mon_s2;
  logic word_evt;  // One pclk cycle per complete word
  logic [23:0] word;

  // The held word is stable for at least 24 link periods after a toggle,
  // far longer than the three pclk edges the crossing takes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      mon_s1 <= 8'h00;
      mon_s2 <= 8'h00;
    end else if (pclk_en) begin
      tog_s1 <= word_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      mon_s1 <= mon_src;
      mon_s2 <= mon_s1;
    end
  end

  assign word_evt = pclk_en && (tog_s2 != tog_s3);
  assign word = hold;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [23:0] dither_reg;  // Active dither word
  logic [23:0] pump_reg;  // Active pump / reference word
  logic accept_en;  // Software gate on link updates
  logic [15:0] word_count;  // Words applied to a register
  logic [2:0] last_sel;  // Select code of the last received word
  logic last_ignored;  // Last word was refused or had an unused select code
  logic [23:0] next_dither_reg;
  logic [23:0] next_pump_reg;
  logic [15:0] next_word_count;
  logic [2:0] next_last_sel;
  logic next_last_ignored;
  logic [1:0] next_mag_code;
  logic [1:0] next_mult_code;
  logic [3:0] next_magnitude;  // Decoded dither magnitude
  logic [2:0] next_multiplier;  // Decoded pump current multiplier

  // Route a complete word by its select bits
  always_comb begin
    next_dither_reg = dither_reg;
    next_pump_reg = pump_reg;
    next_word_count = word_count;
    next_last_sel = last_sel;
    next_last_ignored = last_ignored;
    if (word_evt) begin
      next_last_sel = word[2:0];
      next_last_ignored = 1'b0;
      if (!accept_en) begin
        // Updates held off by software
        next_last_ignored = 1'b1;
      end else if (word[2:0] == SEL_DITHER) begin
        next_dither_reg = word;
        next_word_count = word_count + 16'h0001;
      end else if (word[2:0] == SEL_PUMP) begin
        next_pump_reg = word;
        next_word_count = word_count + 16'h0001;
      end else begin
        // Other select codes belong to registers outside this bank
        next_last_ignored = 1'b1;
      end
    end
    next_mag_code = next_dither_reg[DIT_MAG_MSB:DIT_MAG_LSB];
    next_mult_code = next_pump_reg[CP_MULT_MSB:CP_MULT_LSB];
    // Codes 0..3 give 15, 7, 3, 1 by a right shift of all-ones
    next_magnitude = 4'hf >> next_mag_code;
    // Pump current is the base current times this value
    next_multiplier = {1'b0, next_mult_code} + 3'h1;
  end

  // Register the bank and its decoded outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_reg <= DITHER_RST;
      pump_reg <= PUMP_RST;
      word_count <= 16'h0000;
      last_sel <= 3'h0;
      last_ignored <= 1'b0;
      dither_on_bit <= DITHER_RST[DIT_ON_POS];
      dither_mag_code <= DITHER_RST[DIT_MAG_MSB:DIT_MAG_LSB];
      dither_magnitude <= 4'hf;
      restart_word <= DITHER_RST[DIT_RESTART_MSB:DIT_RESTART_LSB];
      pump_rset_external <= 1'b0;
      pump_mult_code <= 2'h0;
      pump_current_multiplier <= 3'h1;
      phase_offset_multiplier <= 5'h00;
      phase_offset_negative <= 1'b0;
      ref_scale_sel <= 2'h0;
      mon_sel <= MON_SEL_LOCK;
    end else if (pclk_en) begin
      dither_reg <= next_dither_reg;
      pump_reg <= next_pump_reg;
      word_count <= next_word_count;
      last_sel <= next_last_sel;
      last_ignored <= next_last_ignored;
      dither_on_bit <= next_dither_reg[DIT_ON_POS];
      dither_mag_code <= next_mag_code;
      dither_magnitude <= next_magnitude;
      restart_word <= next_dither_reg[DIT_RESTART_MSB:DIT_RESTART_LSB];
      pump_rset_external <= next_pump_reg[RSET_EXT_POS];
      pump_mult_code <= next_mult_code;
      pump_current_multiplier <= next_multiplier;
      // Offset in degrees is 22.5 times this over the current multiplier
      phase_offset_multiplier <= next_pump_reg[OFS_MSB:OFS_LSB];
      phase_offset_negative <= next_pump_reg[OFS_SIGN_POS];
      ref_scale_sel <= next_pump_reg[REF_SCALE_MSB:REF_SCALE_LSB];
      mon_sel <= next_pump_reg[MON_SEL_MSB:MON_SEL_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // Monitor pin multiplexer
  // ----------------------------------------------------------------------
  // Registered so the pin never glitches while the select changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_output_pin <= 1'b0;
    end else if (pclk_en) begin
      monitor_output_pin <= mon_s2[mon_sel];
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic setup_ph;  // Setup cycle of a transfer
  logic access_done;  // Access edge that completes a transfer
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_accept_en;

  assign setup_ph = psel && !penable;
  assign access_done = psel && penable && pready;

  // Decode in the setup cycle so the answer is ready at the first access edge
  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    next_accept_en = accept_en;
    if (setup_ph) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h00000000;
      case (paddr)
        ADDR_CTRL: next_prdata = {31'h00000000, accept_en};
        ADDR_STATUS: next_prdata = {12'h000, last_ignored, last_sel, word_count};
        ADDR_DITHER: next_prdata = {8'h00, dither_reg};
        ADDR_PUMP: next_prdata = {8'h00, pump_reg};
        default: next_pslverr = 1'b1;  // Unmapped address
      endcase
      // Readback words ignore writes; only the control word is writable
    end
    if (access_done && pwrite && (paddr == ADDR_CTRL)) begin
      next_accept_en = pwdata[0];
    end
  end

  // Bus-side registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      accept_en <= CTRL_ACCEPT_RST;
    end else if (pclk_en) begin
      prdata <= next_prdata;
      pready <= setup_ph;
      pslverr <= next_pslverr;
      accept_en <= next_accept_en;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Every property names its own clock and reset: the bank and the link run
  // on unrelated clocks, so one default clocking would not suit the one link-side check.

  // A complete word with the given select while updates are accepted
  sequence s_word_in(logic [2:0] code);
    word_evt && accept_en && (word[2:0] == code);
  endsequence

  // A complete word whose select belongs to no register of this bank
  sequence s_word_foreign;
    word_evt && (word[2:0] != SEL_DITHER) && (word[2:0] != SEL_PUMP);
  endsequence

  // Setup cycle of a transfer while the bank is enabled
  sequence s_apb_setup;
    setup_ph && pclk_en;
  endsequence

  // Setup cycle aimed at an address that the map does not hold
  sequence s_apb_unmapped;
    s_apb_setup ##0 ((paddr != ADDR_CTRL) && (paddr != ADDR_STATUS) &&
      (paddr != ADDR_DITHER) && (paddr != ADDR_PUMP));
  endsequence

  // Routing: an accepted word lands whole, a foreign or refused one does not
  chk_dither_route: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_in(SEL_DITHER) |=>
    (dither_reg == $past(word)) && (restart_word == $past(word[19:3])))
    else $error("dither word not applied");
  chk_pump_route: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_in(SEL_PUMP) |=>
    (pump_reg == $past(word)) && (phase_offset_multiplier == $past(word[16:12])))
    else $error("pump word not applied");
  chk_other_sel: assert property (@(posedge pclk) disable iff (!presetn)
    s_word_foreign |=> $stable(dither_reg) && $stable(pump_reg) && last_ignored)
    else $error("foreign select code changed the bank");
  chk_refused_word: assert property (@(posedge pclk) disable iff (!presetn)
    word_evt && !accept_en |=> $stable(dither_reg) && $stable(pump_reg) && last_ignored)
    else $error("refused word changed the bank");

  // Only a complete word, seen once, may move the bank
  chk_no_word_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !word_evt |=> $stable(dither_reg) && $stable(pump_reg))
    else $error("bank changed without a complete word");
  chk_evt_single: assert property (@(posedge pclk) disable iff (!presetn)
    word_evt |=> !word_evt)
    else $error("one word seen twice");

  // Decoded fields always mirror the active words
  chk_enable_field: assert property (@(posedge pclk) disable iff (!presetn)
    dither_on_bit == dither_reg[DIT_ON_POS]) else $error("dither enable stray");
  chk_restart_field: assert property (@(posedge pclk) disable iff (!presetn)
    restart_word == dither_reg[DIT_RESTART_MSB:DIT_RESTART_LSB])
    else $error("restart field stray");
  chk_rset_field: assert property (@(posedge pclk) disable iff (!presetn)
    pump_rset_external == pump_reg[RSET_EXT_POS]) else $error("resistor source stray");
  chk_offset_field: assert property (@(posedge pclk) disable iff (!presetn)
    phase_offset_multiplier == pump_reg[OFS_MSB:OFS_LSB]) else $error("offset field stray");
  chk_sign_field: assert property (@(posedge pclk) disable iff (!presetn)
    phase_offset_negative == pump_reg[OFS_SIGN_POS]) else $error("offset sign stray");
  chk_scale_field: assert property (@(posedge pclk) disable iff (!presetn)
    ref_scale_sel == pump_reg[REF_SCALE_MSB:REF_SCALE_LSB]) else $error("ref scale stray");
  chk_mon_field: assert property (@(posedge pclk) disable iff (!presetn)
    mon_sel == pump_reg[MON_SEL_MSB:MON_SEL_LSB]) else $error("monitor select stray");

  // Magnitude table, one code per property
  chk_mag_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (dither_mag_code == 2'h0) |-> (dither_magnitude == 4'hf)) else $error("code 00 not 15");
  chk_mag_table: assert property (@(posedge pclk) disable iff (!presetn)
    (dither_mag_code == 2'h1) |-> (dither_magnitude == 4'h7)) else $error("code 01 not 7");
  chk_mag_two: assert property (@(posedge pclk) disable iff (!presetn)
    (dither_mag_code == 2'h2) |-> (dither_magnitude == 4'h3)) else $error("code 10 not 3");
  chk_mag_three: assert property (@(posedge pclk) disable iff (!presetn)
    (dither_mag_code == 2'h3) |-> (dither_magnitude == 4'h1)) else $error("code 11 not 1");

  // Pump current multiplier is one to four
  chk_mult_base: assert property (@(posedge pclk) disable iff (!presetn)
    (pump_mult_code == 2'h0) |-> (pump_current_multiplier == 3'h1)) else $error("not one");
  chk_mult_double: assert property (@(posedge pclk) disable iff (!presetn)
    (pump_mult_code == 2'h1) |-> (pump_current_multiplier == 3'h2)) else $error("not two");
  chk_mult_triple: assert property (@(posedge pclk) disable iff (!presetn)
    (pump_mult_code == 2'h2) |-> (pump_current_multiplier == 3'h3)) else $error("not three");
  chk_mult_range: assert property (@(posedge pclk) disable iff (!presetn)
    (pump_mult_code == 2'h3) |-> (pump_current_multiplier == 3'h4)) else $error("not four");

  // Monitor pin follows its synchronised source one edge late
  chk_monitor_follow: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en ##1 pclk_en |-> monitor_output_pin == $past(mon_s2[mon_sel]))
    else $error("monitor pin not following its source");

  // Bus answers in the first access cycle and for one cycle only
  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup |=> pready)
    else $error("APB answer missing");
  chk_apb_release: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pclk_en |=> !pready)
    else $error("APB answer longer than one cycle");
  chk_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_unmapped |=> pslverr && (prdata == 32'h00000000))
    else $error("unmapped address not refused");

  // Link side: the 24th bit closes the word by itself
  chk_bit_count: assert property (@(posedge link_clk) disable iff (!presetn)
    (bit_cnt == LAST_BIT_IDX) && !link_le |=> (bit_cnt == 5'h00) && (word_tog != $past(word_tog)))
    else $error("24th bit did not close the word");
endmodule : pdr_regs

// ### tb/pdr_host.sv
// Serial programming host that shifts 24-bit words into the register bank.
// Assumes the bench calls send() and that the link clock may stop between words.
`timescale 1ns/1ps
module pdr_host (
  // Serial link toward the device
  output logic link_clk,
  output logic link_data,
  output logic link_le
);
  // ----------------------------------------------------------------
  // Idle state: clock parked low, latch enable low
  // ----------------------------------------------------------------
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    link_le = 1'b0;
  end

  // Shift nbits of w, top bit first; a short word is aborted with the enable
  // Pause stretches each bit so the slow-host path is exercised too
  task send(input logic [23:0] w, input int nbits, input int pause);
    #3.3;
    for (int i = 0; i < nbits; i++) begin
      link_data = w[23 - i];
      #3 link_clk = 1'b1;
      #6 link_clk = 1'b0;
      #(3 + pause);
    end
    if (nbits < 24) begin
      link_le = 1'b1;
      #3 link_clk = 1'b1;
      #6 link_clk = 1'b0;
      #3 link_le = 1'b0;
    end
    // Released data line shows no stale value
    link_data = ~link_data;
  endtask : send
endmodule : pdr_host

// ### tb/pll_dither_pump_ref_regs_tb_top.sv
// Self-checking bench for the dither and pump/reference configuration bank.
// Assumes pdr_pkg, the design and the serial host model are compiled first.
`timescale 1ns/1ps
module pll_dither_pump_ref_regs_tb_top;
  import pdr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus, observed outputs and reference model state
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pclk_en = 1'b1; // Bank clock enable
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] mon_src = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, link_clk, link_data, link_le;
  logic dither_on_bit, pump_rset_external, phase_offset_negative, monitor_output_pin;
  logic [1:0] dither_mag_code, pump_mult_code, ref_scale_sel;
  logic [3:0] dither_magnitude;
  logic [16:0] restart_word, rs;
  logic [2:0] pump_current_multiplier, mon_sel;
  logic [4:0] phase_offset_multiplier;
  logic [23:0] dit_w = DITHER_RST; // Model of the dither word
  logic [23:0] pmp_w = PUMP_RST; // Model of the pump word
  logic [31:0] r, rd;
  logic er;
  logic [2:0] sel_w = 3'h0; // Model of the last select code
  int err_total = 0, samples_checked = 0, applied = 0;
  int mag_tab[4] = '{15, 7, 3, 1};

  always #10 pclk = ~pclk;

  pdr_regs i_pdr_regs (.pclk(pclk), .pclk_en(pclk_en), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .link_data(link_data),
    .link_le(link_le), .mon_src(mon_src), .dither_on_bit(dither_on_bit),
    .dither_mag_code(dither_mag_code), .dither_magnitude(dither_magnitude),
    .restart_word(restart_word), .pump_rset_external(pump_rset_external),
    .pump_mult_code(pump_mult_code), .pump_current_multiplier(pump_current_multiplier),
    .phase_offset_multiplier(phase_offset_multiplier),
    .phase_offset_negative(phase_offset_negative), .ref_scale_sel(ref_scale_sel),
    .mon_sel(mon_sel), .monitor_output_pin(monitor_output_pin));
  pdr_host i_pdr_host (.link_clk(link_clk), .link_data(link_data), .link_le(link_le));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; it waits for pready and only the watchdog ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rdat, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Compare every output and the readback with the model
  task check_all();
    repeat (6) @(posedge pclk);
    chk(dither_on_bit, dit_w[20]);
    chk(dither_mag_code, dit_w[22:21]);
    chk(dither_magnitude, mag_tab[dit_w[22:21]]);
    chk(restart_word, dit_w[19:3]);
    chk(pump_rset_external, pmp_w[18]);
    chk(pump_mult_code, pmp_w[11:10]);
    chk(pump_current_multiplier, pmp_w[11:10] + 1);
    chk(phase_offset_multiplier, pmp_w[16:12]);
    chk(phase_offset_negative, pmp_w[17]);
    chk(ref_scale_sel, pmp_w[20:19]);
    chk(mon_sel, pmp_w[23:21]);
    chk(monitor_output_pin, mon_src[pmp_w[23:21]]);
    apb(1'b0, ADDR_DITHER, 32'h0, rd, er);
    chk(rd, {8'h00, dit_w});
    chk(er, 1'b0);
    apb(1'b0, ADDR_PUMP, 32'h0, rd, er);
    chk(rd, {8'h00, pmp_w});
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    chk(rd[15:0], applied[15:0]);
    chk(rd[18:16], sel_w);
  endtask : check_all

  // Send a whole word and update the model if the device should take it
  task send_word(input logic [23:0] w, input logic ok, input int pause);
    i_pdr_host.send(w, 24, pause);
    sel_w = w[2:0];
    if (ok && w[2:0] == SEL_DITHER) begin
      dit_w = w;
      applied++;
    end else if (ok && w[2:0] == SEL_PUMP) begin
      pmp_w = w;
      applied++;
    end
    check_all();
  endtask : send_word

  task close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Watchdog: the whole run needs well under a millisecond
  initial begin
    #1000000;
    err_total++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h4de8));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    mon_src <= 8'($urandom);
    check_all();
    $display("test reset values done");
    // Every magnitude code, restart word at zero, one, maximum and random
    for (int c = 0; c < 4; c++) begin
      rs = (c == 0) ? 17'h0 : (c == 3) ? 17'h1ffff : (c == 1) ? 17'h1 : 17'($urandom);
      send_word({1'b0, c[1:0], c != 2, rs, SEL_DITHER}, 1'b1, c * 7);
    end
    $display("test dither words done");
    // Every multiplier and reference scale code with random other fields
    for (int c = 0; c < 4; c++) begin
      @(posedge pclk);
      mon_src <= 8'($urandom);
      r = $urandom;
      send_word({r[23:21], c[1:0], r[18:12], c[1:0], r[9:3], SEL_PUMP}, 1'b1, 0);
    end
    $display("test pump words done");
    // Unknown select code is ignored and flagged
    send_word({21'($urandom), 3'h5}, 1'b0, 0);
    chk(rd[19], 1'b1);
    // Accept disabled: a valid word must not land
    apb(1'b1, ADDR_CTRL, 32'h0, rd, er);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0);
    send_word({1'b0, 2'h3, 1'b0, 17'h0abcd, SEL_DITHER}, 1'b0, 0);
    chk(rd[19], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h1, rd, er);
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    chk(rd, 32'h1);
    $display("test refused words done");
    // Aborted half word leaves registers alone, next whole word lands
    i_pdr_host.send({1'b0, 2'h1, 1'b0, 17'h00055, SEL_DITHER}, 12, 0);
    check_all();
    send_word({1'b0, 2'h2, 1'b1, 17'h12345, SEL_DITHER}, 1'b1, 0);
    $display("test abort done");
    // Clock enable low freezes the bank; a word sent meanwhile lands after it
    r = {8'h00, 1'b0, 2'h1, 1'b0, ~dit_w[19:3], SEL_DITHER};
    @(posedge pclk);
    pclk_en <= 1'b0;
    i_pdr_host.send(r[23:0], 24, 0);
    repeat (6) @(posedge pclk);
    chk(restart_word, dit_w[19:3]);
    pclk_en <= 1'b1;
    dit_w = r[23:0];
    sel_w = SEL_DITHER;
    applied++;
    check_all();
    $display("test clock enable done");
    // Read-only write ignored, unmapped address refused
    apb(1'b1, ADDR_DITHER, 32'hffffffff, rd, er);
    check_all();
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test bus errors done");
    // Reset in mid-run brings every field and the counters back
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    dit_w = DITHER_RST;
    pmp_w = PUMP_RST;
    sel_w = 3'h0;
    applied = 0;
    check_all();
    $display("test second reset done");
    close_out();
  end
endmodule : pll_dither_pump_ref_regs_tb_top
